// *** inc/but_pkg.sv ***
// constants, field layouts and carrier types of the basic up-count timer
package but_pkg;
    localparam int          BUT_AW          = 6;
    localparam int          BUT_DW          = 32;
    localparam int          BUT_CW          = 16;
    localparam int          BUT_BEW         = 4;

    // register byte offsets
    localparam logic [5:0]  BUT_OFS_CTRL    = 6'h00;
    localparam logic [5:0]  BUT_OFS_MTC     = 6'h04;
    localparam logic [5:0]  BUT_OFS_REQEN   = 6'h0C;
    localparam logic [5:0]  BUT_OFS_FLAGS   = 6'h10;
    localparam logic [5:0]  BUT_OFS_SWEV    = 6'h14;
    localparam logic [5:0]  BUT_OFS_CNT     = 6'h24;
    localparam logic [5:0]  BUT_OFS_PSC     = 6'h28;
    localparam logic [5:0]  BUT_OFS_RELOAD  = 6'h2C;

    // field positions
    localparam int          BUT_CTRL_LSB    = 0;
    localparam int          BUT_CTRL_MSB    = 3;
    localparam int          BUT_MTC_LSB     = 4;
    localparam int          BUT_MTC_MSB     = 6;
    localparam int          BUT_IRQEN_BIT   = 0;
    localparam int          BUT_DMAEN_BIT   = 8;
    localparam int          BUT_FLAG_BIT    = 0;
    localparam int          BUT_FORCE_BIT   = 0;

    // master trigger select codes
    localparam logic [2:0]  BUT_TRG_RESET   = 3'h0;
    localparam logic [2:0]  BUT_TRG_START   = 3'h1;
    localparam logic [2:0]  BUT_TRG_UPDATE  = 3'h2;

    // reset values and constants
    localparam logic [3:0]  BUT_BE_WORD     = 4'hF;
    localparam logic [15:0] BUT_CNT_RST     = 16'h0000;
    localparam logic [15:0] BUT_CNT_ONE     = 16'h0001;
    localparam logic [2:0]  BUT_MTC_RST     = 3'h0;
    localparam logic [31:0] BUT_RD_ZERO     = 32'h0000_0000;

    // control fields, ordered as they sit in bits 3:0 of the control register
    typedef struct packed {
        logic oneShot;
        logic updSrc;
        logic updInh;
        logic run;
    } butCtrl_t;

    localparam butCtrl_t    BUT_CTRL_RST    = '{oneShot: 1'b0, updSrc: 1'b0,
                                                updInh: 1'b0, run: 1'b0};
endpackage

// *** design/but_prescaler.sv ***
// clock prescaler with a shadow divide value loaded on update events
`timescale 1ns/1ps
`default_nettype none
module but_prescaler
    import but_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // control
    input  wire logic              run,
    input  wire logic              clear,
    input  wire logic              load,
    input  wire logic [BUT_CW-1:0] divIn,
    // count enable
    output logic                   tick
);
    logic [BUT_CW-1:0] shadowReg;
    logic [BUT_CW-1:0] shadowNext;
    logic [BUT_CW-1:0] cntReg;
    logic [BUT_CW-1:0] cntNext;

    always_comb begin
        shadowNext = shadowReg;
        cntNext    = cntReg;
        tick       = 1'b0;
        if (load) begin
            shadowNext = divIn;
        end
        if (clear) begin
            cntNext = BUT_CNT_RST;
        end else if (run) begin
            if (cntReg == shadowReg) begin
                cntNext = BUT_CNT_RST;
                tick    = 1'b1;
            end else begin
                cntNext = cntReg + BUT_CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadowReg <= BUT_CNT_RST;
            cntReg    <= BUT_CNT_RST;
        end else begin
            shadowReg <= shadowNext;
            cntReg    <= cntNext;
        end
    end
endmodule
`default_nettype wire

// *** design/but_timer.sv ***
// basic 16-bit up-count timer with Avalon-MM register slave
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module but_timer
    import but_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // avalon-mm slave
    input  wire logic [BUT_AW-1:0]  avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [BUT_DW-1:0]  avs_writedata,
    input  wire logic [BUT_BEW-1:0] avs_byteenable,
    output logic      [BUT_DW-1:0]  avs_readdata,
    output logic                    avs_waitrequest,
    // timer outputs
    output logic                    syncTriggerOutput,
    output logic                    updateIrq,
    output logic                    updateDmaRequest
);
    typedef enum logic {BUT_BUS_IDLE, BUT_BUS_ANSWER} butBus_t;

    function automatic logic [BUT_DW-1:0] zext16(input logic [BUT_CW-1:0] v);
        zext16 = {{(BUT_DW-BUT_CW){1'b0}}, v};
    endfunction

    function automatic logic isMapped(input logic [BUT_AW-1:0] a);
        isMapped = (a == BUT_OFS_CTRL) || (a == BUT_OFS_MTC) || (a == BUT_OFS_REQEN)
            || (a == BUT_OFS_FLAGS) || (a == BUT_OFS_SWEV) || (a == BUT_OFS_CNT)
            || (a == BUT_OFS_PSC) || (a == BUT_OFS_RELOAD);
    endfunction

    // bus state
    butBus_t            busReg;
    butBus_t            busNext;
    logic               waitReg;
    logic               waitNext;
    logic [BUT_DW-1:0]  rdReg;
    logic [BUT_DW-1:0]  rdNext;

    // registers
    butCtrl_t           ctrlReg;
    butCtrl_t           ctrlNext;
    logic [2:0]         trgSelReg;
    logic [2:0]         trgSelNext;
    logic               irqEnReg;
    logic               irqEnNext;
    logic               dmaEnReg;
    logic               dmaEnNext;
    logic               flagReg;
    logic               flagNext;
    logic [BUT_CW-1:0]  cntReg;
    logic [BUT_CW-1:0]  cntNext;
    logic [BUT_CW-1:0]  pscReg;
    logic [BUT_CW-1:0]  pscNext;
    logic [BUT_CW-1:0]  reloadReg;
    logic [BUT_CW-1:0]  reloadNext;

    // output flops
    logic               trgoReg;
    logic               trgoNext;
    logic               irqReg;
    logic               irqNext;
    logic               dmaReg;
    logic               dmaNext;

    // events
    logic               request;
    logic               accept;
    logic               wrEn;
    logic               ctrlWr;
    logic               cntWr;
    logic               forceEvt;
    logic               tick;
    logic               overflow;
    logic               updateEvt;
    logic               reqEvt;
    logic               startEvt;

    assign request  = avs_read || avs_write;
    assign accept   = request && !waitReg;
    // partial-word writes are dropped
    assign wrEn     = avs_write && !waitReg && (avs_byteenable == BUT_BE_WORD);
    assign ctrlWr   = wrEn && (avs_address == BUT_OFS_CTRL);
    assign cntWr    = wrEn && (avs_address == BUT_OFS_CNT);
    assign forceEvt = wrEn && (avs_address == BUT_OFS_SWEV)
        && avs_writedata[BUT_FORCE_BIT];
    assign overflow = tick && (cntReg == reloadReg);
    // inhibit blocks every update event, forced or not
    assign updateEvt = (overflow || forceEvt) && !ctrlReg.updInh;
    assign reqEvt    = updateEvt && !(forceEvt && ctrlReg.updSrc);
    assign startEvt  = !ctrlReg.run && ctrlNext.run;

    but_prescaler u_prescaler (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (ctrlReg.run),
        .clear (forceEvt),
        .load  (updateEvt),
        .divIn (pscReg),
        .tick  (tick)
    );

    // bus slave: one wait cycle, then the answer edge
    always_comb begin
        busNext  = busReg;
        waitNext = waitReg;
        rdNext   = rdReg;
        unique case (busReg)
            BUT_BUS_IDLE: begin
                if (request) begin
                    busNext  = BUT_BUS_ANSWER;
                    waitNext = 1'b0;
                    rdNext   = BUT_RD_ZERO;
                    if (avs_read && isMapped(avs_address)) begin
                        unique case (avs_address)
                            BUT_OFS_CTRL:   rdNext = {{(BUT_DW-4){1'b0}}, ctrlReg};
                            BUT_OFS_MTC:    rdNext[BUT_MTC_MSB:BUT_MTC_LSB] = trgSelReg;
                            BUT_OFS_REQEN: begin
                                rdNext[BUT_IRQEN_BIT] = irqEnReg;
                                rdNext[BUT_DMAEN_BIT] = dmaEnReg;
                            end
                            BUT_OFS_FLAGS:  rdNext[BUT_FLAG_BIT] = flagReg;
                            BUT_OFS_CNT:    rdNext = zext16(cntReg);
                            BUT_OFS_PSC:    rdNext = zext16(pscReg);
                            BUT_OFS_RELOAD: rdNext = zext16(reloadReg);
                            default:        rdNext = BUT_RD_ZERO;
                        endcase
                    end
                end
            end
            BUT_BUS_ANSWER: begin
                busNext  = BUT_BUS_IDLE;
                waitNext = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busReg  <= BUT_BUS_IDLE;
            waitReg <= 1'b1;
            rdReg   <= BUT_RD_ZERO;
        end else begin
            busReg  <= busNext;
            waitReg <= waitNext;
            rdReg   <= rdNext;
        end
    end

    assign avs_readdata    = rdReg;
    assign avs_waitrequest = waitReg;

    // configuration registers, counter and flag
    always_comb begin
        ctrlNext   = ctrlReg;
        trgSelNext = trgSelReg;
        irqEnNext  = irqEnReg;
        dmaEnNext  = dmaEnReg;
        pscNext    = pscReg;
        reloadNext = reloadReg;
        cntNext    = cntReg;
        flagNext   = flagReg;
        if (updateEvt && ctrlReg.oneShot) begin
            ctrlNext.run = 1'b0;
        end
        if (ctrlWr) begin
            ctrlNext = avs_writedata[BUT_CTRL_MSB:BUT_CTRL_LSB];
        end
        if (wrEn && avs_address == BUT_OFS_MTC) begin
            trgSelNext = avs_writedata[BUT_MTC_MSB:BUT_MTC_LSB];
        end
        if (wrEn && avs_address == BUT_OFS_REQEN) begin
            irqEnNext = avs_writedata[BUT_IRQEN_BIT];
            dmaEnNext = avs_writedata[BUT_DMAEN_BIT];
        end
        if (wrEn && avs_address == BUT_OFS_PSC) begin
            pscNext = avs_writedata[BUT_CW-1:0];
        end
        if (wrEn && avs_address == BUT_OFS_RELOAD) begin
            reloadNext = avs_writedata[BUT_CW-1:0];
        end
        if (wrEn && avs_address == BUT_OFS_FLAGS && !avs_writedata[BUT_FLAG_BIT]) begin
            flagNext = 1'b0;
        end
        // a hardware set wins over a software clear in the same cycle
        if (reqEvt) begin
            flagNext = 1'b1;
        end
        if (forceEvt) begin
            cntNext = BUT_CNT_RST;
        end else if (cntWr) begin
            cntNext = avs_writedata[BUT_CW-1:0];
        end else if (overflow) begin
            cntNext = BUT_CNT_RST;
        end else if (tick) begin
            cntNext = cntReg + BUT_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlReg   <= BUT_CTRL_RST;
            trgSelReg <= BUT_MTC_RST;
            irqEnReg  <= 1'b0;
            dmaEnReg  <= 1'b0;
            pscReg    <= BUT_CNT_RST;
            reloadReg <= BUT_CNT_RST;
            cntReg    <= BUT_CNT_RST;
            flagReg   <= 1'b0;
        end else begin
            ctrlReg   <= ctrlNext;
            trgSelReg <= trgSelNext;
            irqEnReg  <= irqEnNext;
            dmaEnReg  <= dmaEnNext;
            pscReg    <= pscNext;
            reloadReg <= reloadNext;
            cntReg    <= cntNext;
            flagReg   <= flagNext;
        end
    end

    // registered outputs
    always_comb begin
        trgoNext = 1'b0;
        unique case (trgSelReg)
            BUT_TRG_RESET:  trgoNext = forceEvt;
            BUT_TRG_START:  trgoNext = startEvt;
            BUT_TRG_UPDATE: trgoNext = updateEvt;
            default:        trgoNext = 1'b0;
        endcase
        irqNext = flagNext && irqEnNext;
        dmaNext = reqEvt && dmaEnReg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trgoReg <= 1'b0;
            irqReg  <= 1'b0;
            dmaReg  <= 1'b0;
        end else begin
            trgoReg <= trgoNext;
            irqReg  <= irqNext;
            dmaReg  <= dmaNext;
        end
    end

    assign syncTriggerOutput = trgoReg;
    assign updateIrq         = irqReg;
    assign updateDmaRequest  = dmaReg;

    // checks
    run_stop_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (!ctrlReg.run && !cntWr && !forceEvt) |=> $stable(cntReg))
        else $error("counter moved while stopped");

    trg_reset_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (trgSelReg == BUT_TRG_RESET && forceEvt) |=> syncTriggerOutput ##1 !syncTriggerOutput)
        else $error("no one-cycle trigger on counter reset");

    trg_start_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (trgSelReg == BUT_TRG_START && !ctrlReg.run && ctrlWr
             && avs_writedata[BUT_CTRL_LSB]) |=> syncTriggerOutput)
        else $error("no trigger on counter start");

    trg_update_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (trgSelReg == BUT_TRG_UPDATE && $rose(syncTriggerOutput)) |-> $past(updateEvt))
        else $error("update trigger without update event");

    word_only_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (avs_write && !avs_waitrequest && avs_address == BUT_OFS_PSC
             && avs_byteenable != BUT_BE_WORD) |=> $stable(pscReg))
        else $error("partial write changed prescale value");

    dma_gate_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            reqEvt |=> (updateDmaRequest == $past(dmaEnReg)))
        else $error("dma request not gated by its enable");

    irq_level_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (reqEvt && irqEnReg && !(wrEn && avs_address == BUT_OFS_REQEN)) |=> updateIrq)
        else $error("update interrupt missing");

    flag_set_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            reqEvt |=> flagReg)
        else $error("update flag not set");

    force_clear_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            forceEvt |=> (cntReg == BUT_CNT_RST))
        else $error("force update did not clear counter");

    inhibit_quiet_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (forceEvt && ctrlReg.updInh) |=> !updateDmaRequest && cntReg == BUT_CNT_RST)
        else $error("inhibited force update raised a request");

    wrap_zero_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (overflow && !forceEvt && !cntWr) |=> (cntReg == BUT_CNT_RST))
        else $error("counter did not wrap to zero");

    one_shot_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (updateEvt && ctrlReg.oneShot && !ctrlWr) |=> !ctrlReg.run [*2])
        else $error("one-shot did not stop the counter");

    bus_answer_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (request && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
endmodule
`default_nettype wire

// *** tb/but_timer_test.sv ***
// self-checking testbench of the basic up-count timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module but_timer_test;
    import but_pkg::*;

    logic              clk;
    logic              rst_n;
    logic [BUT_AW-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [BUT_DW-1:0] avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [BUT_DW-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              syncTriggerOutput;
    logic              updateIrq;
    logic              updateDmaRequest;
    int                miscompares;
    int                n_tests;
    int                seed;
    int                cyc;
    int                trgCnt;
    int                dmaCnt;
    int                lastDma;
    int                dmaGap;
    int                t0;
    int                d0;
    int                p;
    int                r;
    logic [BUT_DW-1:0] rdData;
    logic [BUT_DW-1:0] c1;
    logic [BUT_DW-1:0] c2;
    logic [5:0]        ofs [9] = '{6'h00, 6'h04, 6'h0C, 6'h10, 6'h14, 6'h24, 6'h28, 6'h2C, 6'h3C};

    but_timer DUT (
        .clk               (clk),
        .rst_n             (rst_n),
        .avs_address       (avs_address),
        .avs_read          (avs_read),
        .avs_write         (avs_write),
        .avs_writedata     (avs_writedata),
        .avs_byteenable    (avs_byteenable),
        .avs_readdata      (avs_readdata),
        .avs_waitrequest   (avs_waitrequest),
        .syncTriggerOutput (syncTriggerOutput),
        .updateIrq         (updateIrq),
        .updateDmaRequest  (updateDmaRequest)
    );

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = BUT_BE_WORD;
        miscompares = 0;
        n_tests = 0;
        seed = 25;
        cyc = 0;
        trgCnt = 0;
        dmaCnt = 0;
        lastDma = 0;
        dmaGap = 0;
    end

    always #10 clk = ~clk;

    // pulse monitor; also cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (syncTriggerOutput === 1'b1) trgCnt++;
        if (updateDmaRequest === 1'b1) begin
            dmaGap = cyc - lastDma;
            lastDma = cyc;
            dmaCnt++;
        end
        if (cyc > 30000) begin
            miscompares++;
            close_out();
        end
    end

    function automatic int expTrg(input int sel);
        return (sel == 0 || sel == 2) ? 1 : 0;
    endfunction

    function automatic int expGap(input int prescale_value, input int lim);
        return (lim + 1) * (prescale_value + 1);
    endfunction

    task automatic busw(input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] be = BUT_BE_WORD);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic busr(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic chkr(input string what, input logic [5:0] a, input logic [31:0] exp);
        busr(a, rdData);
        `CHK(what, exp, rdData)
    endtask

    task automatic waitDma(input int n);
        int k;
        k = 0;
        while (dmaCnt < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ofs[i]) chkr("reset value", ofs[i], 32'h0000_0000);
        busw(6'h3C, 32'h0000_0001);
        chkr("unmapped", 6'h3C, 32'h0000_0000);
        busw(BUT_OFS_CNT, 32'h0000_1234);
        chkr("count write", BUT_OFS_CNT, 32'h0000_1234);
        busw(BUT_OFS_CNT, 32'h0000_0055, 4'h3);
        chkr("partial write", BUT_OFS_CNT, 32'h0000_1234);
        $display("test registers finished");

        busw(BUT_OFS_CNT, 32'h0000_0000);
        busw(BUT_OFS_RELOAD, 32'h0000_0002);
        busw(BUT_OFS_MTC, 32'h0000_0020);
        busw(BUT_OFS_REQEN, 32'h0000_0101);
        t0 = trgCnt;
        d0 = dmaCnt;
        busw(BUT_OFS_CTRL, 32'h0000_0001);
        waitDma(d0 + 3);
        busw(BUT_OFS_CTRL, 32'h0000_0000);
        `CHK("overflow gap", 3, dmaGap)
        `CHK("update trigger", dmaCnt - d0, trgCnt - t0)
        chkr("flag set", BUT_OFS_FLAGS, 32'h0000_0001);
        `CHK("irq level", 1'b1, updateIrq)
        busw(BUT_OFS_FLAGS, 32'h0000_0001);
        chkr("flag keep", BUT_OFS_FLAGS, 32'h0000_0001);
        busw(BUT_OFS_REQEN, 32'h0000_0100);
        @(posedge clk);
        `CHK("irq masked", 1'b0, updateIrq)
        busw(BUT_OFS_REQEN, 32'h0000_0001);
        @(posedge clk);
        `CHK("irq enabled", 1'b1, updateIrq)
        busw(BUT_OFS_FLAGS, 32'h0000_0000);
        chkr("flag clear", BUT_OFS_FLAGS, 32'h0000_0000);
        `CHK("irq cleared", 1'b0, updateIrq)
        $display("test overflow finished");

        busw(BUT_OFS_REQEN, 32'h0000_0101);
        for (int i = 0; i < 5; i++) begin
            p = $unsigned($random(seed)) % 4;
            r = 1 + $unsigned($random(seed)) % 6;
            busw(BUT_OFS_PSC, p);
            busw(BUT_OFS_RELOAD, r);
            busw(BUT_OFS_SWEV, 32'h0000_0001);
            busw(BUT_OFS_CTRL, 32'h0000_0001);
            waitDma(dmaCnt + 3);
            busw(BUT_OFS_CTRL, 32'h0000_0000);
            `CHK("divided period", expGap(p, r), dmaGap)
        end
        $display("test prescaler finished");

        for (int s = 0; s < 8; s++) begin
            busw(BUT_OFS_MTC, s << BUT_MTC_LSB);
            t0 = trgCnt;
            d0 = dmaCnt;
            busw(BUT_OFS_CNT, 32'h0000_0005);
            busw(BUT_OFS_SWEV, 32'h0000_0001);
            chkr("force clears", BUT_OFS_CNT, 32'h0000_0000);
            `CHK("trigger code", expTrg(s), trgCnt - t0)
            `CHK("force dma", 1, dmaCnt - d0)
        end
        chkr("force reads 0", BUT_OFS_SWEV, 32'h0000_0000);
        busw(BUT_OFS_REQEN, 32'h0000_0000);
        busw(BUT_OFS_FLAGS, 32'h0000_0000);
        busw(BUT_OFS_SWEV, 32'h0000_0001);
        // let a wrongly launched pulse reach the monitor
        repeat (2) @(posedge clk);
        `CHK("dma disabled", d0 + 1, dmaCnt)
        $display("test force update finished");

        busw(BUT_OFS_REQEN, 32'h0000_0101);
        for (int m = 0; m < 2; m++) begin
            busw(BUT_OFS_FLAGS, 32'h0000_0000);
            busw(BUT_OFS_MTC, 32'h0000_0000);
            busw(BUT_OFS_CTRL, m ? 32'h0000_0004 : 32'h0000_0002);
            busw(BUT_OFS_CNT, 32'h0000_0005);
            t0 = trgCnt;
            d0 = dmaCnt;
            busw(BUT_OFS_SWEV, 32'h0000_0001);
            chkr("quiet clear", BUT_OFS_CNT, 32'h0000_0000);
            chkr("quiet flag", BUT_OFS_FLAGS, 32'h0000_0000);
            `CHK("quiet dma", d0, dmaCnt)
            `CHK("reset trigger", t0 + 1, trgCnt)
        end
        $display("test inhibit finished");

        busw(BUT_OFS_CTRL, 32'h0000_0000);
        busw(BUT_OFS_MTC, 32'h0000_0010);
        t0 = trgCnt;
        busw(BUT_OFS_CTRL, 32'h0000_0001);
        busw(BUT_OFS_CTRL, 32'h0000_0001);
        busw(BUT_OFS_RELOAD, 32'h0000_FFFF);
        `CHK("start trigger", t0 + 1, trgCnt)
        busr(BUT_OFS_CNT, c1);
        // slowest divide is by 4, so leave room for a count step
        repeat (4) @(posedge clk);
        busr(BUT_OFS_CNT, c2);
        `CHK("counting", 1'b1, c1 !== c2)
        busw(BUT_OFS_CTRL, 32'h0000_0000);
        busr(BUT_OFS_CNT, c1);
        busr(BUT_OFS_CNT, c2);
        `CHK("stopped", c1, c2)
        $display("test run enable finished");

        busw(BUT_OFS_RELOAD, 32'h0000_0003);
        // the forced update raises one request before the run
        d0 = dmaCnt;
        busw(BUT_OFS_SWEV, 32'h0000_0001);
        busw(BUT_OFS_CTRL, 32'h0000_0009);
        waitDma(d0 + 2);
        repeat (20) @(posedge clk);
        `CHK("single update", d0 + 2, dmaCnt)
        chkr("run cleared", BUT_OFS_CTRL, 32'h0000_0008);
        chkr("count stopped", BUT_OFS_CNT, 32'h0000_0000);
        $display("test one shot finished");
        close_out();
    end
endmodule
`default_nettype wire
